// [vic_regs.sv]
// register file and line control of the vectored interrupt unit
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "vic_defs.svh"

module vic_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [31:0] src_i,
    output logic fast_intr_line_n_o,
    output logic normal_intr_line_n_o,
    output logic irq_o
);

    // ==========================================================
    // bus decode
    logic ack_q;
    vic_pkg::vic_req_t req;
    logic acc;
    logic wr;
    logic rd;
    logic [31:0] bmask;
    logic [31:0] wval;
    logic [11:0] wadr;
    logic hit_svr;
    logic [4:0] svr_idx;

    assign req = '{we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i,
                   dat: wb_dat_i};
    assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr = acc & req.we;
    assign rd = acc & ~req.we;
    assign bmask = {{8{req.sel[3]}}, {8{req.sel[2]}},
                    {8{req.sel[1]}}, {8{req.sel[0]}}};
    assign wval = req.dat & bmask;
    assign wadr = {req.adr[11:2], 2'b00};
    assign hit_svr = req.adr[11:7] == `VIC_SVR_PAGE;
    assign svr_idx = req.adr[6:2];

    // ==========================================================
    // source synchronisers
    // a level counts once the second and third stages agree
    logic [31:0] s1_q;
    logic [31:0] s2_q;
    logic [31:0] s3_q;
    logic [31:0] lvl_q;
    logic [31:0] rise;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= `VIC_ZERO32;
            s2_q <= `VIC_ZERO32;
            s3_q <= `VIC_ZERO32;
            lvl_q <= `VIC_ZERO32;
        end else if (ce_i) begin
            s1_q <= src_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
        end
    end

    assign rise = s2_q & s3_q & ~lvl_q;

    // ==========================================================
    // handler words and control
    logic [31:0] svr_q [32];
    logic [31:0] spu_q;
    logic protect_q;

    always_ff @(posedge clk_i) begin
        if (wr && hit_svr && ce_i) begin
            svr_q[svr_idx] <= (svr_q[svr_idx] & ~bmask) | wval;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spu_q <= `VIC_ZERO32;
            protect_q <= 1'b0;
        end else if (ce_i && wr) begin
            if (wadr == `VIC_OFF_SPU) begin
                spu_q <= (spu_q & ~bmask) | wval;
            end
            if (wadr == `VIC_OFF_CTRL && req.sel[0]) begin
                protect_q <= req.dat[`VIC_PROTECT_BIT];
            end
        end
    end

    // ==========================================================
    // source selection
    // lowest numbered pending enabled source from 1 upward wins; no priority levels here
    logic [31:0] pend_q;
    logic [31:0] mask_q;
    logic [31:0] act_norm;
    logic norm_any;
    logic fast_act;
    logic [4:0] pick_id;
    logic [31:0] pick_vec;

    assign act_norm = pend_q & mask_q & `VIC_NORM_SRCS;
    assign norm_any = |act_norm;
    assign fast_act = pend_q[`VIC_FAST_BIT] & mask_q[`VIC_FAST_BIT];

    always_comb begin
        pick_id = `VIC_ZERO_ID;
        for (int i = 31; i >= 1; i--) begin
            if (act_norm[i]) begin
                pick_id = 5'(i);
            end
        end
    end

    assign pick_vec = svr_q[pick_id];

    // ==========================================================
    // service state
    vic_pkg::vic_state_t st_q;
    logic [4:0] cur_id_q;
    logic rd_ivr;
    logic rd_fvr;
    logic take;
    logic [31:0] ack_clr;

    assign rd_ivr = rd && wadr == `VIC_OFF_IVR;
    assign rd_fvr = rd && wadr == `VIC_OFF_FVR;
    // under protection a debugger read must not disturb service
    assign take = protect_q ? (wr && wadr == `VIC_OFF_IVR)
                         : (rd_ivr && norm_any);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= vic_pkg::VIC_IDLE;
            cur_id_q <= `VIC_ZERO_ID;
        end else if (ce_i) begin
            if (rd_ivr && norm_any) begin
                cur_id_q <= pick_id;
            end
            if (take) begin
                st_q <= vic_pkg::VIC_BUSY;
            end else if (wr && wadr == `VIC_OFF_EOS) begin
                st_q <= vic_pkg::VIC_IDLE;
            end
        end
    end

    always_comb begin
        ack_clr = `VIC_ZERO32;
        if (take) begin
            ack_clr[protect_q ? cur_id_q : pick_id] = 1'b1;
        end
        if (rd_fvr && fast_act && !protect_q) begin
            ack_clr[`VIC_FAST_BIT] = 1'b1;
        end
    end

    // ==========================================================
    // pending and enabled bitmaps
    // a new edge in the clearing cycle is kept: set wins
    logic [31:0] cmd_en;
    logic [31:0] cmd_dis;
    logic [31:0] cmd_clr;

    // zero bits and unselected bytes leave a source as it was
    assign cmd_en = (wr && wadr == `VIC_OFF_IECR) ? wval
                                                  : `VIC_ZERO32;
    assign cmd_dis = (wr && wadr == `VIC_OFF_IDCR) ? wval : `VIC_ZERO32;
    assign cmd_clr = (wr && wadr == `VIC_OFF_ICCR) ? wval : `VIC_ZERO32;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_q <= `VIC_ZERO32;
        end else if (ce_i) begin
            pend_q <= (pend_q & ~cmd_clr & ~ack_clr) | rise;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= `VIC_ZERO32;
        end else if (ce_i) begin
            mask_q <= (mask_q | cmd_en) & ~cmd_dis;
        end
    end

    // ==========================================================
    // processor lines
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_intr_line_n_o <= 1'b1;
            normal_intr_line_n_o <= 1'b1;
        end else if (ce_i) begin
            fast_intr_line_n_o <= ~fast_act;
            normal_intr_line_n_o <=
                ~(norm_any && st_q == vic_pkg::VIC_IDLE);
        end
    end

    // ==========================================================
    // spurious events and interrupt output
    logic [1:0] evst_q;
    logic [1:0] evmsk_q;
    logic [1:0] ev_set;
    logic [1:0] ev_w1c;

    assign ev_set = {rd_fvr && !fast_act, rd_ivr && !norm_any};
    assign ev_w1c = (wr && wadr == `VIC_OFF_EVST) ? wval[1:0]
                                                  : `VIC_ZERO_EV;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evst_q <= `VIC_ZERO_EV;
            evmsk_q <= `VIC_ZERO_EV;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            evst_q <= (evst_q & ~ev_w1c) | ev_set;
            if (wr && wadr == `VIC_OFF_EVMSK) begin
                evmsk_q <= wval[1:0];
            end
            irq_o <= |(evst_q & evmsk_q);
        end
    end

    // ==========================================================
    // read mux and acknowledge
    logic [31:0] rd_d;

    always_comb begin
        rd_d = `VIC_ZERO32;
        if (hit_svr) begin
            rd_d = svr_q[svr_idx];
        end else begin
            unique case (wadr)
                `VIC_OFF_IVR: begin
                    rd_d = norm_any ? pick_vec : spu_q;
                end
                `VIC_OFF_FVR: begin
                    rd_d = fast_act ? svr_q[`VIC_FAST_BIT] : spu_q;
                end
                `VIC_OFF_ISR: rd_d = {27'h0000000, cur_id_q};
                `VIC_OFF_IPR: rd_d = pend_q;
                `VIC_OFF_IMR: rd_d = mask_q;
                `VIC_OFF_CISR: begin
                    rd_d = {30'h00000000, ~normal_intr_line_n_o,
                            ~fast_intr_line_n_o};
                end
                `VIC_OFF_SPU: rd_d = spu_q;
                `VIC_OFF_CTRL: rd_d = {31'h00000000, protect_q};
                `VIC_OFF_EVST: rd_d = {30'h00000000, evst_q};
                `VIC_OFF_EVMSK: rd_d = {30'h00000000, evmsk_q};
                default: rd_d = `VIC_ZERO32;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            wb_dat_o <= `VIC_ZERO32;
        end else if (ce_i) begin
            ack_q <= acc;
            if (rd) begin
                wb_dat_o <= rd_d;
            end
        end
    end

    assign wb_ack_o = ack_q;

    // ==========================================================
    // checks
    a_handler_keep: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && wr && hit_svr && req.sel == 4'hF
        |=> svr_q[$past(svr_idx)] == $past(wb_dat_i))
        else $error("handler word not kept");

    a_normal_vector: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && rd_ivr && norm_any
        |=> wb_ack_o && wb_dat_o == $past(pick_vec))
        else $error("normal readout not handler");

    a_normal_spur: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && rd_ivr && !norm_any
        |=> wb_dat_o == $past(spu_q) && evst_q[`VIC_EV_NSPUR])
        else $error("normal readout not spurious");

    a_fast_value: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && rd_fvr && fast_act
        |=> wb_dat_o == $past(svr_q[`VIC_FAST_BIT]))
        else $error("fast readout not handler 0");

    a_fast_spur: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && rd_fvr && !fast_act
        |=> wb_dat_o == $past(spu_q) && evst_q[`VIC_EV_FSPUR])
        else $error("fast readout not spurious");

    a_status_id: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && rd && wadr == `VIC_OFF_ISR
        |=> wb_dat_o == {27'h0000000, $past(cur_id_q)})
        else $error("status not current number");

    a_pend_set: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && (|rise) |=> (pend_q & $past(rise)) == $past(rise))
        else $error("new edge not pending");

    a_mask_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && rd && wadr == `VIC_OFF_IMR
        |=> wb_dat_o == $past(mask_q))
        else $error("enabled bitmap read wrong");

    a_clear_pend: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && (|cmd_clr) && !(|rise)
        |=> (pend_q & $past(cmd_clr)) == 32'h00000000)
        else $error("clear left pending bit");

    a_enable_mask: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && (|cmd_en) |=> (mask_q & $past(cmd_en)) == $past(cmd_en)
            && (mask_q & ~$past(cmd_en)) == ($past(mask_q) & ~$past(cmd_en)))
        else $error("enable command wrong");

    a_disable_mask: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && (|cmd_dis) |=> (mask_q & $past(cmd_dis)) == 32'h00000000)
        else $error("disable command wrong");

    a_protect_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && protect_q && rd_ivr && st_q == vic_pkg::VIC_IDLE
        |=> st_q == vic_pkg::VIC_IDLE)
        else $error("protected read acknowledged");

    a_fast_line: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i |=> fast_intr_line_n_o == !$past(fast_act))
        else $error("fast line wrong");

    a_norm_line: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && norm_any && st_q == vic_pkg::VIC_IDLE
        |=> !normal_intr_line_n_o)
        else $error("normal line not asserted");

    a_line_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && rd && wadr == `VIC_OFF_CISR
        |=> wb_dat_o == {30'h00000000, !$past(normal_intr_line_n_o),
                         !$past(fast_intr_line_n_o)})
        else $error("line status read wrong");

endmodule
`default_nettype wire

// [vic_defs.svh]
// offsets, field positions and reset values of the vectored interrupt unit
`ifndef VIC_DEFS_SVH
`define VIC_DEFS_SVH

`define VIC_SVR_PAGE 5'h01
`define VIC_OFF_IVR 12'h100
`define VIC_OFF_FVR 12'h104
`define VIC_OFF_ISR 12'h108
`define VIC_OFF_IPR 12'h10C
`define VIC_OFF_IMR 12'h110
`define VIC_OFF_CISR 12'h114
`define VIC_OFF_IECR 12'h120
`define VIC_OFF_IDCR 12'h124
`define VIC_OFF_ICCR 12'h128
`define VIC_OFF_EOS 12'h130
`define VIC_OFF_SPU 12'h134
`define VIC_OFF_CTRL 12'h138
`define VIC_OFF_EVST 12'h150
`define VIC_OFF_EVMSK 12'h154

`define VIC_FAST_BIT 0
`define VIC_PROTECT_BIT 0
`define VIC_EV_NSPUR 0
`define VIC_EV_FSPUR 1
`define VIC_NORM_SRCS 32'hFFFFFFFE
`define VIC_ZERO32 32'h00000000
`define VIC_ZERO_ID 5'h00
`define VIC_ZERO_EV 2'h0

`endif

// [vic_pkg.sv]
// types shared by the vectored interrupt unit
`default_nettype none
package vic_pkg;
    typedef struct packed {
        logic we;
        logic [11:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } vic_req_t;

    typedef enum logic [1:0] {
        VIC_IDLE = 2'b01,
        VIC_BUSY = 2'b10
    } vic_state_t;
endpackage
`default_nettype wire

// [vic_regs_tail_unused.sv]
// empty compile unit kept out of the build
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [vic_core_model.sv]
// core-side model that watches the two interrupt lines
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fast_intr_line_n_i,
    input wire logic normal_intr_line_n_i,
    output logic fast_active_o,
    output logic normal_active_o
);
    // ==========================================
    // line sampling
    // one input flop, as a core would have, so a line is seen a cycle late
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_active_o <= 1'b0;
            normal_active_o <= 1'b0;
        end else begin
            fast_active_o <= !fast_intr_line_n_i;
            normal_active_o <= !normal_intr_line_n_i;
        end
    end
endmodule
`default_nettype wire

// [tb_vectored_irq_register_file.sv]
// testbench of the vectored interrupt unit register file
`timescale 1ns/1ps
`default_nettype none
`include "vic_defs.svh"
module tb_vectored_irq_register_file;
    // ==========================================
    // signals
    localparam logic [31:0] SPUR = 32'h5A5A0000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] src = 32'h00000000;
    logic [31:0] rdat;
    logic [31:0] q;
    logic ack;
    logic fast_n;
    logic norm_n;
    logic irq;
    logic fast_act;
    logic norm_act;
    int errors = 0;
    int checks_done = 0;
    int i;

    always #50 clk_i = ~clk_i;

    vic_regs uut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .src_i(src),
        .fast_intr_line_n_o(fast_n), .normal_intr_line_n_o(norm_n),
        .irq_o(irq)
    );
    vic_core_model core (
        .clk_i(clk_i), .rst_i(rst_i), .fast_intr_line_n_i(fast_n),
        .normal_intr_line_n_i(norm_n), .fast_active_o(fast_act),
        .normal_active_o(norm_act)
    );

    // ==========================================
    // tasks
    function automatic logic [31:0] hnd(input int n);
        return 32'hC0DE0000 + 32'(n * 4);
    endfunction

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    // classic cycle: hold until ack, take data at that edge, then release
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            errors++;
            $display("unexpected bus wait: expected ack seen none");
            tally_and_finish();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input string nm, input logic [11:0] a,
                      input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk(nm, e, q);
    endtask

    // sources are edge-latched after a 3 flop sync: 8 cycles is ample
    task automatic raise(input logic [31:0] s);
        @(posedge clk_i);
        src <= s;
        repeat (8) @(posedge clk_i);
    endtask

    // ==========================================
    // sequence
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("pending", `VIC_OFF_IPR, 32'h00000000);
        rd("enabled", `VIC_OFF_IMR, 32'h00000000);
        rd("lines", `VIC_OFF_CISR, 32'h00000000);
        // handlers first, spurious too, before any enable
        for (i = 0; i < 32; i++) begin
            wr({`VIC_SVR_PAGE, i[4:0], 2'b00}, hnd(i));
        end
        rd("hnd 31", {`VIC_SVR_PAGE, 5'h1F, 2'b00}, hnd(31));
        rd("hnd 17", {`VIC_SVR_PAGE, 5'h11, 2'b00}, hnd(17));
        wr(`VIC_OFF_SPU, SPUR);
        wr(`VIC_OFF_IECR, 32'h0000000F);
        wr(`VIC_OFF_IDCR, 32'h00000002);
        wr(`VIC_OFF_IDCR, 32'h00000000);
        rd("enabled", `VIC_OFF_IMR, 32'h0000000D);
        wr(`VIC_OFF_EVMSK, 32'h00000001);
        rd("normal readout", `VIC_OFF_IVR, SPUR);
        repeat (2) @(posedge clk_i);
        chk("irq", 32'h00000001, 32'(irq));
        wr(`VIC_OFF_EVST, 32'h00000001);
        repeat (2) @(posedge clk_i);
        chk("irq", 32'h00000000, 32'(irq));
        raise(32'h00000008);
        rd("pending", `VIC_OFF_IPR, 32'h00000008);
        chk("normal line", 32'h00000001, 32'(norm_act));
        rd("lines", `VIC_OFF_CISR, 32'h00000002);
        rd("normal readout", `VIC_OFF_IVR, hnd(3));
        rd("status", `VIC_OFF_ISR, 32'h00000003);
        chk("normal line", 32'h00000000, 32'(norm_act));
        rd("pending", `VIC_OFF_IPR, 32'h00000000);
        wr(`VIC_OFF_EOS, 32'h00000000);
        raise(32'h00000009);
        chk("fast line", 32'h00000001, 32'(fast_act));
        rd("lines", `VIC_OFF_CISR, 32'h00000001);
        rd("fast readout", `VIC_OFF_FVR, hnd(0));
        rd("fast readout", `VIC_OFF_FVR, SPUR);
        chk("irq", 32'h00000000, 32'(irq));
        raise(32'h00000029);
        rd("pending", `VIC_OFF_IPR, 32'h00000020);
        rd("lines", `VIC_OFF_CISR, 32'h00000000);
        wr(`VIC_OFF_ICCR, 32'h00000020);
        rd("pending", `VIC_OFF_IPR, 32'h00000000);
        wr(`VIC_OFF_CTRL, 32'h00000001);
        raise(32'h0000002D);
        rd("normal readout", `VIC_OFF_IVR, hnd(2));
        rd("pending", `VIC_OFF_IPR, 32'h00000004);
        wr(`VIC_OFF_IVR, 32'h00000000);
        rd("pending", `VIC_OFF_IPR, 32'h00000000);
        rd("status", `VIC_OFF_ISR, 32'h00000002);
        rd("unmapped", 12'h200, 32'h00000000);
        tally_and_finish();
    end
endmodule
`default_nettype wire
